// ### rtl/rtc_pkg.sv
package rtc_pkg;

   // timebase and pclk
   localparam int XTAL_HZ = 32768;
   localparam int XTAL_DIV_W = 15;
   localparam int PCLK_HZ = 10000000;
   localparam int ALARM_PULSE_MS = 250;
   localparam int ALARM_PULSE_CYCLES = (PCLK_HZ / 1000) * ALARM_PULSE_MS;
   localparam int PULSE_CNT_W = 22;

   // register byte addresses
   localparam logic [7:0] OFF_SEC = 8'h00;
   localparam logic [7:0] OFF_MIN = 8'h04;
   localparam logic [7:0] OFF_HOUR = 8'h08;
   localparam logic [7:0] OFF_DATE = 8'h0c;
   localparam logic [7:0] OFF_MONTH = 8'h10;
   localparam logic [7:0] OFF_YEAR = 8'h14;
   localparam logic [7:0] OFF_DOW = 8'h18;
   localparam logic [7:0] OFF_CTRL = 8'h1c;
   localparam logic [7:0] OFF_TGT_SEC = 8'h20;
   localparam logic [7:0] OFF_TGT_MIN = 8'h24;
   localparam logic [7:0] OFF_TGT_HOUR = 8'h28;
   localparam logic [7:0] OFF_TGT_DATE = 8'h2c;
   localparam logic [7:0] OFF_TGT_MONTH = 8'h30;
   localparam logic [7:0] OFF_TGT_YEAR = 8'h34;
   localparam logic [7:0] OFF_TGT_DOW = 8'h38;
   localparam logic [7:0] OFF_TGT_FIELDS = 8'h3c;
   localparam logic [7:0] OFF_STATUS = 8'h40;
   localparam logic [7:0] OFF_MASK = 8'h44;
   localparam logic [7:0] OFF_STATE = 8'h48;

   // control register fields
   localparam int CTRL_ALARM_EN = 0;
   localparam int CTRL_REPEAT = 1;
   localparam int CTRL_AUTO_CLEAR = 2;
   localparam int CTRL_FOUT_EN = 3;
   localparam int CTRL_LOW_POWER = 4;
   localparam int CTRL_IRQ_PIN_EN = 5;
   localparam int CTRL_FSEL_LSB = 8;
   localparam int FSEL_W = 4;

   // alarm field enable bits
   localparam int AF_SEC = 0;
   localparam int AF_MIN = 1;
   localparam int AF_HOUR = 2;
   localparam int AF_DATE = 3;
   localparam int AF_MONTH = 4;
   localparam int AF_YEAR = 5;
   localparam int AF_DOW = 6;
   localparam int AF_W = 7;

   // status / mask bits
   localparam int ST_ALARM = 0;
   localparam int ST_SECOND = 1;
   localparam int ST_SUPPLY = 2;
   localparam int ST_W = 3;

   // counter limits
   localparam logic [5:0] SEC_MAX = 6'h3b;
   localparam logic [5:0] MIN_MAX = 6'h3b;
   localparam logic [4:0] HOUR_MAX = 5'h17;
   localparam logic [3:0] MONTH_MAX = 4'hc;
   localparam logic [6:0] YEAR_MAX = 7'h63;
   localparam logic [2:0] DOW_MAX = 3'h6;

   // reset values
   localparam logic [4:0] RST_DATE = 5'h01;
   localparam logic [3:0] RST_MONTH = 4'h1;
   localparam logic [FSEL_W-1:0] RST_FSEL = 4'h0;

   typedef struct packed {
      logic [6:0] year;
      logic [3:0] month;
      logic [4:0] date;
      logic [2:0] dow;
      logic [4:0] hour;
      logic [5:0] min;
      logic [5:0] sec;
   } time_t;

   // analog supply comparator results
   typedef struct packed {
      logic vdd_below_backup;
      logic vdd_below_trip;
      logic vdd_above_backup;
      logic vdd_above_trip;
   } supply_cmp_t;

endpackage

// ### rtl/rtc_tick_gen.sv
`timescale 1ns/100ps
`default_nettype none
module rtc_tick_gen #(
   parameter int DIV_W = rtc_pkg::XTAL_DIV_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic crystal_in,
   input wire logic restart,
   output logic tick,
   output logic [DIV_W-1:0] phase,
   output logic xtal_level
);

   typedef struct packed {
      logic prev;
      logic [DIV_W-1:0] cnt;
      logic tick;
   } tick_state_t;

   tick_state_t st_d;
   tick_state_t st_q;

   if ((1 << DIV_W) != rtc_pkg::XTAL_HZ)
   begin : g_check
      $error("prescaler width does not divide the timebase to one second");
   end

   always_comb
   begin
      st_d = st_q;
      st_d.tick = 1'b0;
      st_d.prev = crystal_in;
      if (restart)
      begin
         st_d.cnt = '0;
      end
      else if (crystal_in && !st_q.prev)
      begin
         st_d.cnt = st_q.cnt + 1'b1; // R18
         st_d.tick = &st_q.cnt; // R18
      end
   end

   // never reset by supply changes, so no second is lost across switchover
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d; // R19
      end
   end

   assign tick = st_q.tick;
   assign phase = st_q.cnt;
   assign xtal_level = st_q.prev;

endmodule
`default_nettype wire

// ### rtl/rtc_core.sv
// Chosen here: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// R01: seconds, minutes and hours are separate counters, each its own register.
// R02: date, month, year and weekday counters advance on time-of-day rollover.
// R03: leap years corrected automatically, valid through year 2099.
// R04: timebase is a 32.768kHz clock from crystal or external source on crystal_in.
// R05: alarm compares any chosen field set; all selected fields matching raises alarm.
// R06: alarm shows as pollable flag, optionally also drives the interrupt pin.
// R07: repeat mode re-alarms on every later match, giving periodic interrupts.
// R08: interrupt pin is open-drain active low, pulled low on alarm.
// R09: frequency pin drives selected division of timebase, enabled by software, open-drain.
// R10: in backup mode serial clock input and data driver are disabled.
// R11: serial data is bidirectional with open-drain driver.
// R12: backup entered only below backup minus hysteresis and below trip level; with low_power set the code enters on below backup alone.
// R13: host writes register 08h only while main supply exceeds backup.
// R14: single mode holds pin low with flag; pulsed mode pulls low 250ms per match.
// R15: 15 selectable output frequencies; frequency output enabled disables alarm.
// R16: counters stay halted after power-up until a clock register is written.
// R17: alarm flag stays set until cleared, unless auto-clear is enabled.
// R18: one-second tick from counting 32768 timebase cycles advances seconds.
// R19: timekeeping and alarm continue unchanged across supply switchover.
module rtc_core #(
   parameter int ADDR_W = 8,
   parameter int PULSE_CYCLES = rtc_pkg::ALARM_PULSE_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic crystal_in,
   output logic crystal_out,
   input wire rtc_pkg::supply_cmp_t supply,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_pull_req,
   output logic scl_gated,
   output logic sda_gated,
   output logic sda_out,
   output logic sda_oe,
   output logic irq_n_out,
   output logic irq_n_oe,
   output logic fout_out,
   output logic fout_oe,
   output logic backup_mode
);

   localparam int FSEL_W = rtc_pkg::FSEL_W;
   localparam int PCW = rtc_pkg::PULSE_CNT_W;
   localparam int DIV_W = rtc_pkg::XTAL_DIV_W;

   typedef struct packed {
      rtc_pkg::time_t tm;
      rtc_pkg::time_t tgt;
      logic [rtc_pkg::AF_W-1:0] tgt_fields;
      logic running;
      logic upd;
      logic restart;
      logic alarm_en;
      logic repeat_sel;
      logic auto_clear;
      logic fout_en;
      logic low_power;
      logic irq_pin_en;
      logic [FSEL_W-1:0] fsel;
      logic [rtc_pkg::ST_W-1:0] status;
      logic [rtc_pkg::ST_W-1:0] mask;
      logic backup;
      logic [PCW-1:0] pulse_cnt;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic irq;
      logic irq_n_oe;
      logic fout_oe;
      logic xtal_out;
      logic scl_gated;
      logic sda_gated;
      logic sda_oe;
   } core_state_t;

   core_state_t st_d;
   core_state_t st_q;

   logic tick;
   logic [DIV_W-1:0] phase;
   logic xtal_level;

   if (ADDR_W < 7 || PULSE_CYCLES < 1 || PULSE_CYCLES >= (1 << PCW))
   begin : g_check
      $error("unsupported address width or alarm pulse length");
   end

   rtc_tick_gen #(
      .DIV_W(DIV_W)
   ) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .crystal_in(crystal_in), // R04
      .restart(st_q.restart),
      .tick(tick),
      .phase(phase),
      .xtal_level(xtal_level)
   );

   function automatic logic [4:0] days_in_month(input logic [3:0] month, input logic [6:0] year);
      logic [4:0] days;
      unique case (month)
         4'h2: days = (year[1:0] == 2'h0) ? 5'h1d : 5'h1c; // R03
         4'h4, 4'h6, 4'h9, 4'hb: days = 5'h1e;
         default: days = 5'h1f;
      endcase
      return days;
   endfunction

   function automatic rtc_pkg::time_t next_time(input rtc_pkg::time_t t);
      rtc_pkg::time_t n;
      n = t;
      if (t.sec < rtc_pkg::SEC_MAX)
      begin
         n.sec = t.sec + 6'h01; // R01
      end
      else
      begin
         n.sec = '0;
         if (t.min < rtc_pkg::MIN_MAX)
         begin
            n.min = t.min + 6'h01;
         end
         else
         begin
            n.min = '0;
            if (t.hour < rtc_pkg::HOUR_MAX)
            begin
               n.hour = t.hour + 5'h01;
            end
            else
            begin
               n.hour = '0;
               n.dow = (t.dow >= rtc_pkg::DOW_MAX) ? 3'h0 : t.dow + 3'h1; // R02
               if (t.date < days_in_month(t.month, t.year))
               begin
                  n.date = t.date + 5'h01; // R02
               end
               else
               begin
                  n.date = rtc_pkg::RST_DATE;
                  if (t.month < rtc_pkg::MONTH_MAX)
                  begin
                     n.month = t.month + 4'h1;
                  end
                  else
                  begin
                     n.month = rtc_pkg::RST_MONTH;
                     n.year = (t.year >= rtc_pkg::YEAR_MAX) ? 7'h00 : t.year + 7'h01; // R03
                  end
               end
            end
         end
      end
      return n;
   endfunction

   // selected waveform: 1 is the timebase itself, 2..15 halve it each step
   function automatic logic freq_wave(input logic [FSEL_W-1:0] fsel, input logic [DIV_W-1:0] ph,
                                      input logic lvl);
      logic w;
      w = lvl;
      for (int i = 0; i < DIV_W - 1; i++)
      begin
         if (fsel == FSEL_W'(i + 2))
         begin
            w = ph[i]; // R09
         end
      end
      return w;
   endfunction

   always_comb
   begin
      logic setup;
      logic wr;
      logic rd;
      logic hit;
      logic [31:0] rdat;
      logic [7:0] addr;
      logic alarm_active;
      logic match;
      logic ev_alarm;
      logic [rtc_pkg::ST_W-1:0] clr;
      logic [rtc_pkg::ST_W-1:0] ev;
      logic backup_next;
      setup = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      hit = 1'b1;
      rdat = '0;
      addr = 8'(paddr);
      alarm_active = 1'b0;
      match = 1'b0;
      ev_alarm = 1'b0;
      clr = '0;
      ev = '0;
      backup_next = 1'b0;
      st_d = st_q;

      // apb: answer in the first access cycle, data latched at setup
      setup = psel && !penable;
      wr = psel && penable && st_q.pready && pwrite;
      rd = psel && penable && st_q.pready && !pwrite;
      unique case (addr)
         rtc_pkg::OFF_SEC: rdat = 32'(st_q.tm.sec); // R01
         rtc_pkg::OFF_MIN: rdat = 32'(st_q.tm.min); // R01
         rtc_pkg::OFF_HOUR: rdat = 32'(st_q.tm.hour); // R01
         rtc_pkg::OFF_DATE: rdat = 32'(st_q.tm.date); // R02
         rtc_pkg::OFF_MONTH: rdat = 32'(st_q.tm.month); // R02
         rtc_pkg::OFF_YEAR: rdat = 32'(st_q.tm.year); // R02
         rtc_pkg::OFF_DOW: rdat = 32'(st_q.tm.dow); // R02
         rtc_pkg::OFF_CTRL:
         begin
            rdat[rtc_pkg::CTRL_ALARM_EN] = st_q.alarm_en;
            rdat[rtc_pkg::CTRL_REPEAT] = st_q.repeat_sel;
            rdat[rtc_pkg::CTRL_AUTO_CLEAR] = st_q.auto_clear;
            rdat[rtc_pkg::CTRL_FOUT_EN] = st_q.fout_en;
            rdat[rtc_pkg::CTRL_LOW_POWER] = st_q.low_power;
            rdat[rtc_pkg::CTRL_IRQ_PIN_EN] = st_q.irq_pin_en;
            rdat[rtc_pkg::CTRL_FSEL_LSB +: FSEL_W] = st_q.fsel;
         end
         rtc_pkg::OFF_TGT_SEC: rdat = 32'(st_q.tgt.sec);
         rtc_pkg::OFF_TGT_MIN: rdat = 32'(st_q.tgt.min);
         rtc_pkg::OFF_TGT_HOUR: rdat = 32'(st_q.tgt.hour);
         rtc_pkg::OFF_TGT_DATE: rdat = 32'(st_q.tgt.date);
         rtc_pkg::OFF_TGT_MONTH: rdat = 32'(st_q.tgt.month);
         rtc_pkg::OFF_TGT_YEAR: rdat = 32'(st_q.tgt.year);
         rtc_pkg::OFF_TGT_DOW: rdat = 32'(st_q.tgt.dow);
         rtc_pkg::OFF_TGT_FIELDS: rdat = 32'(st_q.tgt_fields);
         rtc_pkg::OFF_STATUS: rdat = 32'(st_q.status); // R06
         rtc_pkg::OFF_MASK: rdat = 32'(st_q.mask);
         rtc_pkg::OFF_STATE: rdat = {30'h0, st_q.running, st_q.backup};
         default: hit = 1'b0;
      endcase
      if (paddr != ADDR_W'(addr))
      begin
         hit = 1'b0;
      end
      st_d.pready = setup;
      st_d.pslverr = setup && !hit;
      if (setup)
      begin
         st_d.prdata = hit ? rdat : 32'h0;
      end

      // timekeeping; a time write below overrides this tick
      st_d.upd = 1'b0;
      st_d.restart = 1'b0;
      if (tick && st_q.running)
      begin
         st_d.tm = next_time(st_q.tm); // R18
         st_d.upd = 1'b1;
      end

      if (wr && hit && !st_q.pslverr)
      begin
         unique case (addr)
            rtc_pkg::OFF_SEC:
            begin
               st_d.tm.sec = pwdata[5:0];
               st_d.restart = 1'b1;
            end
            rtc_pkg::OFF_MIN: st_d.tm.min = pwdata[5:0];
            rtc_pkg::OFF_HOUR: st_d.tm.hour = pwdata[4:0];
            rtc_pkg::OFF_DATE: st_d.tm.date = pwdata[4:0];
            rtc_pkg::OFF_MONTH: st_d.tm.month = pwdata[3:0];
            rtc_pkg::OFF_YEAR: st_d.tm.year = pwdata[6:0];
            rtc_pkg::OFF_DOW: st_d.tm.dow = pwdata[2:0];
            rtc_pkg::OFF_CTRL:
            begin
               st_d.alarm_en = pwdata[rtc_pkg::CTRL_ALARM_EN];
               st_d.repeat_sel = pwdata[rtc_pkg::CTRL_REPEAT];
               st_d.auto_clear = pwdata[rtc_pkg::CTRL_AUTO_CLEAR];
               st_d.fout_en = pwdata[rtc_pkg::CTRL_FOUT_EN]; // R09
               st_d.low_power = pwdata[rtc_pkg::CTRL_LOW_POWER];
               st_d.irq_pin_en = pwdata[rtc_pkg::CTRL_IRQ_PIN_EN];
               st_d.fsel = pwdata[rtc_pkg::CTRL_FSEL_LSB +: FSEL_W]; // R15
            end
            rtc_pkg::OFF_TGT_SEC: st_d.tgt.sec = pwdata[5:0];
            rtc_pkg::OFF_TGT_MIN: st_d.tgt.min = pwdata[5:0];
            rtc_pkg::OFF_TGT_HOUR: st_d.tgt.hour = pwdata[4:0];
            rtc_pkg::OFF_TGT_DATE: st_d.tgt.date = pwdata[4:0];
            rtc_pkg::OFF_TGT_MONTH: st_d.tgt.month = pwdata[3:0];
            rtc_pkg::OFF_TGT_YEAR: st_d.tgt.year = pwdata[6:0];
            rtc_pkg::OFF_TGT_DOW: st_d.tgt.dow = pwdata[2:0];
            rtc_pkg::OFF_TGT_FIELDS: st_d.tgt_fields = pwdata[rtc_pkg::AF_W-1:0];
            rtc_pkg::OFF_STATUS: clr = pwdata[rtc_pkg::ST_W-1:0];
            rtc_pkg::OFF_MASK: st_d.mask = pwdata[rtc_pkg::ST_W-1:0];
            default:
            begin
            end
         endcase
         if (addr <= rtc_pkg::OFF_DOW)
         begin
            st_d.running = 1'b1; // R16
         end
      end

      // auto-clear: a completed status read drops the alarm flag
      if (rd && addr == rtc_pkg::OFF_STATUS && st_q.auto_clear)
      begin
         clr[rtc_pkg::ST_ALARM] = 1'b1; // R17
      end

      // alarm compare runs on the settled time, one cycle after the update
      alarm_active = st_q.alarm_en && !st_q.fout_en; // R15
      match = (!st_q.tgt_fields[rtc_pkg::AF_SEC] || st_q.tm.sec == st_q.tgt.sec) &&
              (!st_q.tgt_fields[rtc_pkg::AF_MIN] || st_q.tm.min == st_q.tgt.min) &&
              (!st_q.tgt_fields[rtc_pkg::AF_HOUR] || st_q.tm.hour == st_q.tgt.hour) &&
              (!st_q.tgt_fields[rtc_pkg::AF_DATE] || st_q.tm.date == st_q.tgt.date) &&
              (!st_q.tgt_fields[rtc_pkg::AF_MONTH] || st_q.tm.month == st_q.tgt.month) &&
              (!st_q.tgt_fields[rtc_pkg::AF_YEAR] || st_q.tm.year == st_q.tgt.year) &&
              (!st_q.tgt_fields[rtc_pkg::AF_DOW] || st_q.tm.dow == st_q.tgt.dow); // R05
      ev_alarm = st_q.upd && alarm_active && (|st_q.tgt_fields) && match; // R05

      if (ev_alarm && st_q.repeat_sel)
      begin
         st_d.pulse_cnt = PCW'(PULSE_CYCLES); // R07
      end
      else if (st_q.pulse_cnt != '0)
      begin
         st_d.pulse_cnt = st_q.pulse_cnt - 1'b1; // R14
      end

      // supply switchover; backup also needs trip unless low-power switching
      backup_next = st_q.backup;
      if (!st_q.backup)
      begin
         if (supply.vdd_below_backup && (supply.vdd_below_trip || st_q.low_power))
         begin
            backup_next = 1'b1; // R12
         end
      end
      else if (supply.vdd_above_backup || supply.vdd_above_trip)
      begin
         backup_next = 1'b0;
      end
      st_d.backup = backup_next;

      // sticky status, set wins over clear
      ev[rtc_pkg::ST_ALARM] = ev_alarm; // R06
      ev[rtc_pkg::ST_SECOND] = st_q.upd;
      ev[rtc_pkg::ST_SUPPLY] = backup_next != st_q.backup;
      st_d.status = (st_q.status & ~clr) | ev; // R17
      st_d.irq = |(st_d.status & st_d.mask);

      // pins; in backup the serial pins look idle-high to the engine
      if (st_d.repeat_sel)
      begin
         st_d.irq_n_oe = st_d.irq_pin_en && st_d.pulse_cnt != '0; // R14
      end
      else
      begin
         st_d.irq_n_oe = st_d.irq_pin_en && st_d.status[rtc_pkg::ST_ALARM]; // R08
      end
      st_d.fout_oe = st_q.fout_en && st_q.fsel != '0 &&
                     !freq_wave(st_q.fsel, phase, xtal_level); // R09
      st_d.xtal_out = !crystal_in;
      st_d.scl_gated = backup_next ? 1'b1 : scl_in; // R10
      st_d.sda_gated = backup_next ? 1'b1 : sda_in; // R10
      st_d.sda_oe = !backup_next && sda_pull_req; // R11
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q <= '0;
         st_q.tm.date <= rtc_pkg::RST_DATE;
         st_q.tm.month <= rtc_pkg::RST_MONTH;
         st_q.fsel <= rtc_pkg::RST_FSEL;
         st_q.scl_gated <= 1'b1;
         st_q.sda_gated <= 1'b1;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // open-drain pins only ever drive low
   assign prdata = st_q.prdata;
   assign pready = st_q.pready;
   assign pslverr = st_q.pslverr;
   assign irq = st_q.irq;
   assign crystal_out = st_q.xtal_out;
   assign scl_gated = st_q.scl_gated;
   assign sda_gated = st_q.sda_gated;
   assign sda_out = st_q.restart & 1'b0;
   assign sda_oe = st_q.sda_oe;
   assign irq_n_out = st_q.restart & 1'b0;
   assign irq_n_oe = st_q.irq_n_oe;
   assign fout_out = st_q.restart & 1'b0;
   assign fout_oe = st_q.fout_oe;
   assign backup_mode = st_q.backup;

endmodule
`default_nettype wire

// ### test/rtc_core_props.sv
`timescale 1ns/100ps
`default_nettype none
module rtc_core_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire rtc_pkg::supply_cmp_t supply,
   input wire logic scl_in,
   input wire logic sda_pull_req,
   input wire logic scl_gated,
   input wire logic sda_gated,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic irq_n_out,
   input wire logic fout_out,
   input wire logic backup_mode
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence setup_s;
      psel && !penable;
   endsequence
   sequence answer_s;
      pready ##1 !pready;
   endsequence
   sequence enter_s;
      supply.vdd_below_backup && supply.vdd_below_trip && !supply.vdd_above_backup && !supply.vdd_above_trip;
   endsequence

   chk_apb_answer:
      assert property (setup_s |=> answer_s) else $error("no single-cycle answer to setup");
   chk_err_with_ready:
      assert property (pslverr |-> pready) else $error("error response without ready");
   chk_enter_backup:
      assert property (enter_s |=> backup_mode) else $error("backup not entered");
   chk_stay_normal:
      assert property (!backup_mode && !supply.vdd_below_backup |=> !backup_mode) else $error("early switchover");
   chk_leave_backup:
      assert property (supply.vdd_above_backup || supply.vdd_above_trip |=> !backup_mode) else $error("backup kept");
   chk_bus_gated:
      assert property (backup_mode |-> scl_gated && sda_gated && !sda_oe) else $error("bus alive in backup");
   chk_scl_follows:
      assert property (!backup_mode ##1 !backup_mode |-> scl_gated == $past(scl_in)) else $error("scl not passed");
   chk_sda_drive:
      assert property (sda_pull_req ##1 !backup_mode |-> sda_oe) else $error("sda not pulled");
   chk_open_drain:
      assert property (!sda_out && !irq_n_out && !fout_out) else $error("pin driven high");
endmodule

bind rtc_core rtc_core_props u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .supply(supply), .scl_in(scl_in), .sda_pull_req(sda_pull_req), .scl_gated(scl_gated),
   .sda_gated(sda_gated), .sda_out(sda_out), .sda_oe(sda_oe), .irq_n_out(irq_n_out),
   .fout_out(fout_out), .backup_mode(backup_mode)
);
`default_nettype wire

// ### test/i2c_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// pins pulled up; every party can only pull low
module i2c_host_model (
   input wire logic sda_oe,
   input wire logic host_scl_low,
   input wire logic host_sda_low,
   output logic scl_in,
   output logic sda_in
);
   // no serial writes are issued, so none can fall in a low-supply phase
   assign scl_in = !host_scl_low;
   assign sda_in = !(host_sda_low || sda_oe);
endmodule
`default_nettype wire

// ### test/rtc_calendar_alarm_backup_tb.sv
`timescale 1ns/100ps
`default_nettype none
module rtc_calendar_alarm_backup_tb;
   localparam int PULSE = 20;
   typedef struct {logic [7:0] a; logic [1:0] f; logic [31:0] d;} row_t;
   logic pclk = 1'h0, presetn, psel, penable, pwrite, pready, pslverr, irq, crystal_in = 1'h0, crystal_out, er, last;
   logic scl_in, sda_in, sda_pull_req, scl_gated, sda_gated, sda_out, sda_oe, irq_n_out, irq_n_oe;
   logic fout_out, fout_oe, backup_mode, host_scl_low, host_sda_low;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   rtc_pkg::supply_cmp_t supply;
   int err_count, n_tests, cnt;
   // low power bit, comparators, expected backup
   logic [5:0] sup [4] = '{6'h31, 6'h26, 6'h10, 6'h19};
   // f bit0 write, bit1 error expected
   row_t rows [16] = '{'{rtc_pkg::OFF_SEC, 2'h0, 32'h0}, '{rtc_pkg::OFF_MONTH, 2'h0, 32'h1},
      '{rtc_pkg::OFF_STATE, 2'h0, 32'h0}, '{rtc_pkg::OFF_TGT_FIELDS, 2'h1, 32'hff},
      '{rtc_pkg::OFF_TGT_FIELDS, 2'h0, 32'h7f}, '{rtc_pkg::OFF_CTRL, 2'h1, 32'hffffffff},
      '{rtc_pkg::OFF_CTRL, 2'h0, 32'hf3f}, '{8'h4c, 2'h3, 32'h5}, '{8'h4c, 2'h2, 32'h0},
      '{rtc_pkg::OFF_MIN, 2'h1, 32'h3b}, '{rtc_pkg::OFF_HOUR, 2'h1, 32'h17}, '{rtc_pkg::OFF_DATE, 2'h1, 32'h1c},
      '{rtc_pkg::OFF_MONTH, 2'h1, 32'h2}, '{rtc_pkg::OFF_YEAR, 2'h1, 32'h4}, '{rtc_pkg::OFF_DOW, 2'h1, 32'h6},
      '{rtc_pkg::OFF_SEC, 2'h1, 32'h3b}};
   // leap day follows 28 feb of year 4
   row_t tm [7] = '{'{rtc_pkg::OFF_SEC, 2'h0, 32'h0}, '{rtc_pkg::OFF_MIN, 2'h0, 32'h0},
      '{rtc_pkg::OFF_HOUR, 2'h0, 32'h0}, '{rtc_pkg::OFF_DATE, 2'h0, 32'h1d}, '{rtc_pkg::OFF_MONTH, 2'h0, 32'h2},
      '{rtc_pkg::OFF_YEAR, 2'h0, 32'h4}, '{rtc_pkg::OFF_DOW, 2'h0, 32'h0}};

   rtc_core #(.PULSE_CYCLES(PULSE)) uut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .crystal_in(crystal_in),
      .crystal_out(crystal_out), .supply(supply), .scl_in(scl_in), .sda_in(sda_in), .sda_pull_req(sda_pull_req),
      .scl_gated(scl_gated), .sda_gated(sda_gated), .sda_out(sda_out), .sda_oe(sda_oe), .irq_n_out(irq_n_out),
      .irq_n_oe(irq_n_oe), .fout_out(fout_out), .fout_oe(fout_oe), .backup_mode(backup_mode)
   );
   i2c_host_model host (
      .sda_oe(sda_oe), .host_scl_low(host_scl_low), .host_sda_low(host_sda_low), .scl_in(scl_in), .sda_in(sda_in)
   );

   always #50 pclk = ~pclk;
   // fastest timebase the sampler can see: one second is 65536 cycles
   always @(posedge pclk) crystal_in <= ~crystal_in;

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'h1 && n < 20);
      rd = prdata;
      er = pslverr;
      chk("pready", {31'h0, pready}, 32'h1);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic play(input row_t r);
      apb(r.a, r.f[0], r.d);
      chk("slverr", {31'h0, er}, {31'h0, r.f[1]});
      if (!r.f[0])
         chk("rdata", rd, r.d);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      #(100 * 90000);
      err_count++;
      test_done;
   end

   initial
   begin
      {presetn, psel, penable, pwrite, sda_pull_req, host_scl_low, host_sda_low} = 7'h0;
      {paddr, pwdata, err_count, n_tests} = '0;
      supply = 4'h3;
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      foreach (rows[i])
         play(rows[i]);
      // fsel 1 follows the crystal, fsel 2 halves it
      for (int fs = 1; fs < 3; fs++)
      begin
         apb(rtc_pkg::OFF_CTRL, 1'h1, {20'h0, fs[3:0], 8'h08});
         repeat (3) @(posedge pclk);
         last = fout_oe;
         cnt = 0;
         repeat (16)
         begin
            @(posedge pclk);
            cnt += (fout_oe !== last);
            last = fout_oe;
         end
         chk("fout toggles", cnt, 32 >> fs);
         // crystal toggles each cycle, so the inverted late copy equals it now
         chk("xtal out", {31'h0, crystal_out}, {31'h0, crystal_in});
      end
      foreach (sup[i])
      begin
         apb(rtc_pkg::OFF_CTRL, 1'h1, {27'h0, sup[i][5], 4'h0});
         supply <= sup[i][4:1];
         repeat (3) @(posedge pclk);
         chk("backup", {31'h0, backup_mode}, {31'h0, sup[i][0]});
      end
      host_scl_low <= 1'h1;
      host_sda_low <= 1'h1;
      sda_pull_req <= 1'h1;
      repeat (3) @(posedge pclk);
      chk("gated", {29'h0, scl_gated, sda_gated, sda_oe}, 32'h6);
      supply <= 4'h3;
      repeat (3) @(posedge pclk);
      chk("normal", {29'h0, scl_gated, sda_gated, sda_oe}, 32'h1);
      {host_scl_low, host_sda_low, sda_pull_req} <= 3'h0;
      apb(rtc_pkg::OFF_STATUS, 1'h1, 32'h7);
      apb(rtc_pkg::OFF_TGT_FIELDS, 1'h1, 32'h1);
      apb(rtc_pkg::OFF_MASK, 1'h1, 32'h1);
      apb(rtc_pkg::OFF_CTRL, 1'h1, 32'h23);
      cnt = 0;
      while (irq_n_oe !== 1'h1 && cnt < 70000)
      begin
         @(posedge pclk);
         cnt++;
      end
      cnt = 0;
      while (irq_n_oe === 1'h1 && cnt < 100)
      begin
         @(posedge pclk);
         cnt++;
      end
      chk("pulse", cnt, PULSE);
      chk("irq", {31'h0, irq}, 32'h1);
      foreach (tm[i])
         play(tm[i]);
      play(row_t'{rtc_pkg::OFF_STATUS, 2'h0, 32'h3});
      apb(rtc_pkg::OFF_CTRL, 1'h1, 32'h21);
      repeat (2) @(posedge pclk);
      chk("pin single", {31'h0, irq_n_oe}, 32'h1);
      apb(rtc_pkg::OFF_CTRL, 1'h1, 32'h25);
      play(row_t'{rtc_pkg::OFF_STATUS, 2'h0, 32'h3});
      play(row_t'{rtc_pkg::OFF_STATUS, 2'h0, 32'h2});
      apb(rtc_pkg::OFF_STATUS, 1'h1, 32'h1);
      repeat (2) @(posedge pclk);
      chk("pin clear", {30'h0, irq_n_oe, irq}, 32'h0);
      apb(rtc_pkg::OFF_MASK, 1'h1, 32'h2);
      repeat (2) @(posedge pclk);
      chk("irq mask", {31'h0, irq}, 32'h1);
      apb(rtc_pkg::OFF_STATUS, 1'h1, 32'h2);
      repeat (2) @(posedge pclk);
      chk("irq clear", {31'h0, irq}, 32'h0);
      test_done;
   end
endmodule
`default_nettype wire
